/* File: verilog/gpio_wake_monitor.sv */
// gpio wake monitor and deep sleep regulator control, apb register slave
// assumes inputs synchronous to pclk, zero-wait apb, open-drain pin resolved
// outside by the enable
`timescale 1ns/10ps
module gpio_wake_monitor
(
	input  wire logic        pclk,                      // 200 MHz clock
	input  wire logic        presetn,                   // async reset, low
	input  wire logic        ce,                        // clock enable
	input  wire logic        psel,                      // apb select
	input  wire logic        penable,                   // apb enable
	input  wire logic        pwrite,                    // apb direction
	input  wire logic [15:0] paddr,                     // apb byte address
	input  wire logic [31:0] pwdata,                    // apb write data
	output logic      [31:0] prdata,                    // apb read data
	output logic             pready,                    // apb ready
	output logic             pslverr,                   // apb error
	input  wire logic [23:0] gpio_in,                   // ports c,b,a
	input  wire logic        cpwrupreq,                 // debug powerup req
	input  wire logic        csyspwrupreq,              // system powerup req
	input  wire logic        pin7_normal_o,             // normal pin output
	input  wire logic        pin7_normal_oe,            // normal pin enable
	output logic             regulator_control_pin_o,   // pin output
	output logic             regulator_control_pin_oe,  // pin drive enable
	output logic             vreg_1v8_en,               // 1v8 regulator on
	output logic             vreg_1v25_en,              // 1v25 regulator on
	output logic             deep_sleep,                // in deep sleep
	output logic             csyspwrupack,              // system powerup ack
	output logic             irq                        // level interrupt
);
	wake_link_if lnk ();

	wake_pkg::power_state_e   state_q;
	wake_pkg::power_state_e   state_d;
	logic [7:0]               mask_a_q;
	logic [7:0]               mask_b_q;
	logic [7:0]               mask_c_q;
	logic [9:0]               src_en_q;
	logic [9:0]               flags_q;
	logic                     filter_q;
	logic                     inhibit_q;
	logic                     ext_sel_q;
	logic [1:0]               vreg_q;
	logic                     dbg_req_q;
	logic                     sys_req_q;
	logic [31:0]              prdata_q;
	logic                     pready_q;
	logic                     pslverr_q;
	logic                     reg_pin_o_q;
	logic                     reg_pin_oe_q;
	logic                     v18_q;
	logic                     v125_q;
	logic                     sleep_q;
	logic                     ack_q;
	logic                     irq_q;
	logic                     setup;
	logic                     wr_fire;
	logic                     sleep_go;
	logic                     core_write;
	logic [9:0]               wake_vec;
	logic                     wake_any;
	logic                     sleep_next;
	logic [31:0]              rd_word;
	logic                     rd_hit;

	////////////////////////////////////////////////////////////////
	// helpers: pin monitor and interrupt status
	pin_change_detect u_detect
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.lnk     (lnk)
	);

	wake_irq_ctrl u_irq
	(
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.lnk     (lnk)
	);

	// link drive
	assign lnk.pins       = gpio_in;
	assign lnk.mask       = {mask_c_q, mask_b_q, mask_a_q};
	assign lnk.monitor_en = src_en_q[wake_pkg::MON_EN_BIT];
	assign lnk.filter_en  = filter_q;
	assign lnk.arm        = sleep_go;
	assign lnk.irq_set    = {sleep_go, wake_any};
	assign lnk.irq_clr    = (wr_fire && paddr == wake_pkg::IRQ_STAT_OFF)
		? pwdata[1:0] : 2'h0;
	assign lnk.mask_wr    = wr_fire && paddr == wake_pkg::IRQ_MASK_OFF;
	assign lnk.mask_wdata = pwdata[1:0];

	////////////////////////////////////////////////////////////////
	// bus phase decode; a write lands only on the access edge
	assign setup   = psel && !penable;
	assign wr_fire = psel && penable && pready_q && pwrite;

	// sleep request only from run; a repeat while asleep is ignored
	assign sleep_go = wr_fire && paddr == wake_pkg::SLEEP_OFF
		&& pwdata[wake_pkg::SLEEP_BIT] && state_q == wake_pkg::RUN_S;
	assign core_write = wr_fire && paddr == wake_pkg::CORE_TRIG_OFF
		&& pwdata[wake_pkg::CORE_TRIG_BIT];

	// wake sources, each gated by its enable bit
	always_comb
	begin
		wake_vec = 10'h000;
		wake_vec[wake_pkg::GPIO_FLAG_BIT] = lnk.change;
		wake_vec[wake_pkg::CORE_BIT] = core_write
			&& src_en_q[wake_pkg::CORE_BIT];
		wake_vec[wake_pkg::DBG_BIT] = dbg_req_q
			&& src_en_q[wake_pkg::DBG_BIT];
		wake_vec[wake_pkg::SYS_BIT] = sys_req_q
			&& src_en_q[wake_pkg::SYS_BIT];
	end

	assign wake_any = state_q == wake_pkg::SLEEP_S && (|wake_vec);

	////////////////////////////////////////////////////////////////
	// power state machine
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			wake_pkg::RUN_S:
				if (sleep_go)
					state_d = wake_pkg::SLEEP_S;
			wake_pkg::SLEEP_S:
				if (wake_any)
					state_d = wake_pkg::RUN_S;
		endcase
	end

	assign sleep_next = state_d == wake_pkg::SLEEP_S;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			state_q <= wake_pkg::RUN_S;
		else if (ce)
			state_q <= state_d;

	////////////////////////////////////////////////////////////////
	// wake mask registers; upper bits are not stored
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mask_a_q <= wake_pkg::MASK_RST;
			mask_b_q <= wake_pkg::MASK_RST;
			mask_c_q <= wake_pkg::MASK_RST;
		end
		else if (ce && wr_fire)
		begin
			if (paddr == wake_pkg::MASK_A_OFF)
				mask_a_q <= pwdata[7:0];
			if (paddr == wake_pkg::MASK_B_OFF)
				mask_b_q <= pwdata[7:0];
			if (paddr == wake_pkg::MASK_C_OFF)
				mask_c_q <= pwdata[7:0];
		end

	// wake control, filter, external select, regulator enables
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			src_en_q  <= wake_pkg::SRC_EN_RST;
			filter_q  <= 1'b0;
			ext_sel_q <= wake_pkg::EXT_SEL_RST;
			vreg_q    <= wake_pkg::VREG_RST;
		end
		else if (ce && wr_fire)
		begin
			if (paddr == wake_pkg::SRC_EN_OFF)
				src_en_q <= pwdata[9:0];
			if (paddr == wake_pkg::FILTER_OFF)
				filter_q <= pwdata[0];
			if (paddr == wake_pkg::EXT_SEL_OFF)
				ext_sel_q <= pwdata[0];
			if (paddr == wake_pkg::VREG_OFF)
				vreg_q <= pwdata[1:0];
		end

	// ack inhibit: the power-down sequence clears it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			inhibit_q <= 1'b0;
		else if (ce)
		begin
			if (sleep_go)
				inhibit_q <= 1'b0;
			else if (wr_fire && paddr == wake_pkg::ACK_BLK_OFF)
				inhibit_q <= pwdata[0];
		end

	// wake flags hold the cause of the last wake until the next sleep
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			flags_q <= 10'h000;
		else if (ce)
		begin
			if (sleep_go)
				flags_q <= 10'h000;
			else if (wake_any)
				flags_q <= wake_vec;
		end

	// debug and system powerup request levels, registered for status and wake
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			dbg_req_q <= 1'b0;
			sys_req_q <= 1'b0;
		end
		else if (ce)
		begin
			dbg_req_q <= cpwrupreq;
			sys_req_q <= csyspwrupreq;
		end

	////////////////////////////////////////////////////////////////
	// read mux; unmapped addresses answer zero with an error
	always_comb
	begin
		rd_word = wake_pkg::ZERO_WORD;
		rd_hit  = 1'b1;
		unique case (paddr)
			wake_pkg::SRC_EN_OFF:    rd_word = wake_pkg::word_of(src_en_q);
			wake_pkg::CORE_TRIG_OFF: rd_word = wake_pkg::ZERO_WORD;
			wake_pkg::FLAGS_OFF:     rd_word = wake_pkg::word_of(flags_q);
			wake_pkg::DBG_REQ_OFF:   rd_word = {31'h0, dbg_req_q};
			wake_pkg::SYS_REQ_OFF:   rd_word = {31'h0, sys_req_q};
			wake_pkg::SYS_ACK_OFF:   rd_word = {31'h0, ack_q};
			wake_pkg::ACK_BLK_OFF:   rd_word = {31'h0, inhibit_q};
			wake_pkg::MASK_A_OFF:    rd_word = {24'h00_0000, mask_a_q};
			wake_pkg::MASK_B_OFF:    rd_word = {24'h00_0000, mask_b_q};
			wake_pkg::MASK_C_OFF:    rd_word = {24'h00_0000, mask_c_q};
			wake_pkg::FILTER_OFF:    rd_word = {31'h0, filter_q};
			wake_pkg::SLEEP_OFF:     rd_word = {31'h0, sleep_q};
			wake_pkg::EXT_SEL_OFF:   rd_word = {31'h0, ext_sel_q};
			wake_pkg::VREG_OFF:      rd_word = {30'h0, vreg_q};
			wake_pkg::IRQ_STAT_OFF:  rd_word = {30'h0, lnk.irq_status};
			wake_pkg::IRQ_MASK_OFF:  rd_word = {30'h0, lnk.irq_mask};
			default:                 rd_hit  = 1'b0;
		endcase
	end

	// answer registered in setup so the access phase has one cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata_q  <= wake_pkg::ZERO_WORD;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (ce)
		begin
			pready_q  <= setup;
			pslverr_q <= setup && !rd_hit;
			if (setup && !pwrite)
				prdata_q <= rd_word;
		end

	////////////////////////////////////////////////////////////////
	// regulator and pin outputs follow the next power state
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			v18_q   <= 1'b1;
			v125_q  <= 1'b1;
			sleep_q <= 1'b0;
		end
		else if (ce)
		begin
			v18_q   <= vreg_q[0] && !sleep_next;
			v125_q  <= vreg_q[1] && !sleep_next;
			sleep_q <= sleep_next;
		end

	// forced open-drain: only ever pulls low, released when awake
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			reg_pin_o_q  <= 1'b0;
			reg_pin_oe_q <= 1'b0;
		end
		else if (ce)
		begin
			if (ext_sel_q)
			begin
				reg_pin_o_q  <= 1'b0;
				reg_pin_oe_q <= sleep_next;
			end
			else
			begin
				reg_pin_o_q  <= pin7_normal_o;
				reg_pin_oe_q <= pin7_normal_oe;
			end
		end

	// powerup ack held off while inhibited or asleep
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ack_q <= 1'b0;
		else if (ce)
			ack_q <= sys_req_q && !inhibit_q && !sleep_next;

	// interrupt level; one cycle behind the status bits
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			irq_q <= 1'b0;
		else if (ce)
			irq_q <= |(lnk.irq_status & lnk.irq_mask);

	assign prdata                   = prdata_q;
	assign pready                   = pready_q;
	assign pslverr                  = pslverr_q;
	assign regulator_control_pin_o  = reg_pin_o_q;
	assign regulator_control_pin_oe = reg_pin_oe_q;
	assign vreg_1v8_en              = v18_q;
	assign vreg_1v25_en             = v125_q;
	assign deep_sleep               = sleep_q;
	assign csyspwrupack             = ack_q;
	assign irq                      = irq_q;
endmodule : gpio_wake_monitor

/* File: pkg/wake_pkg.sv */
// constants, types and register map of the gpio wake monitor
// assumes one 200 MHz clock and an apb master with 32-bit data
// Behaviour
// - port b wake mask is a 32-bit register, pins 0..7 in the low byte, reset zero.
// - port c wake mask is a 32-bit register, pins 0..7 in the low byte, reset zero.
// - a one in a mask bit makes a level change on that pin a wake source.
// - a zero in a mask bit makes the pin's changes irrelevant for waking.
// - both internal regulators are switched off while in deep sleep.
// - in deep sleep the open-drain regulator pin is pulled low, else released.
// - per-pin masks act only while the monitor enable bit 0 of wake control is set.
// - a pin-change wake sets the gpio wake flag, bit 0 of wake status.
// - with external regulator select set the regulator pin is forced open-drain.
package wake_pkg;

	localparam int unsigned ADDR_W  = 16;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned PORT_W  = 8;
	localparam int unsigned PIN_W   = 24;
	localparam int unsigned FLAG_W  = 10;
	localparam int unsigned IRQ_W   = 2;
	localparam int unsigned VREG_W  = 2;

	// register byte offsets
	localparam logic [15:0] SRC_EN_OFF    = 16'h0020;
	localparam logic [15:0] CORE_TRIG_OFF = 16'h0024;
	localparam logic [15:0] FLAGS_OFF     = 16'h0028;
	localparam logic [15:0] DBG_REQ_OFF   = 16'h0034;
	localparam logic [15:0] SYS_REQ_OFF   = 16'h0038;
	localparam logic [15:0] SYS_ACK_OFF   = 16'h003C;
	localparam logic [15:0] ACK_BLK_OFF   = 16'h0040;
	localparam logic [15:0] MASK_A_OFF    = 16'hBC08;
	localparam logic [15:0] MASK_B_OFF    = 16'hBC0C;
	localparam logic [15:0] MASK_C_OFF    = 16'hBC10;
	localparam logic [15:0] FILTER_OFF    = 16'hBC1C;
	localparam logic [15:0] SLEEP_OFF     = 16'hBC20;
	localparam logic [15:0] EXT_SEL_OFF   = 16'hBC24;
	localparam logic [15:0] VREG_OFF      = 16'hBC28;
	localparam logic [15:0] IRQ_STAT_OFF  = 16'hBC2C;
	localparam logic [15:0] IRQ_MASK_OFF  = 16'hBC30;

	// field positions
	localparam int unsigned MON_EN_BIT    = 0;
	localparam int unsigned GPIO_FLAG_BIT = 0;
	localparam int unsigned CORE_BIT      = 7;
	localparam int unsigned DBG_BIT       = 8;
	localparam int unsigned SYS_BIT       = 9;
	localparam int unsigned CORE_TRIG_BIT = 5;
	localparam int unsigned SLEEP_BIT     = 0;
	localparam int unsigned IRQ_WAKE_BIT  = 0;
	localparam int unsigned IRQ_SLEEP_BIT = 1;

	// reset values
	localparam logic [FLAG_W-1:0] SRC_EN_RST  = 10'h200;
	localparam logic [PORT_W-1:0] MASK_RST    = 8'h00;
	localparam logic              EXT_SEL_RST = 1'b1;
	localparam logic [VREG_W-1:0] VREG_RST    = 2'h3;
	localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;

	typedef enum logic [0:0]
	{
		RUN_S   = 1'b0,
		SLEEP_S = 1'b1
	} power_state_e;

	// zero-extend a narrow field into a bus word
	function automatic logic [DATA_W-1:0] word_of
	(
		input logic [FLAG_W-1:0] v
	);
		word_of = {22'h00_0000, v};
	endfunction : word_of

endpackage : wake_pkg

/* File: pkg/wake_link_if.sv */
// signals between the wake controller and its pin and irq helpers
// assumes all parties share pclk
`timescale 1ns/10ps
interface wake_link_if;
	logic [23:0] pins;        // sampled gpio levels
	logic [23:0] mask;        // per-pin wake masks
	logic        monitor_en;  // global monitor enable
	logic        filter_en;   // two-sample filter
	logic        arm;         // snapshot pulse at sleep entry
	logic        change;      // enabled pin differs from snapshot
	logic [1:0]  irq_set;     // event pulses
	logic [1:0]  irq_clr;     // write-one-to-clear pulses
	logic        mask_wr;     // irq mask write strobe
	logic [1:0]  mask_wdata;  // irq mask write data
	logic [1:0]  irq_status;  // sticky status
	logic [1:0]  irq_mask;    // irq mask

	modport detect (input pins, mask, monitor_en, filter_en, arm,
		output change);
	modport irqm (input irq_set, irq_clr, mask_wr, mask_wdata,
		output irq_status, irq_mask);
	modport ctrl (output pins, mask, monitor_en, filter_en, arm,
		irq_set, irq_clr, mask_wr, mask_wdata,
		input change, irq_status, irq_mask);
endinterface : wake_link_if

/* File: verilog/pin_change_detect.sv */
// pin level tracking and change detection against a sleep-entry snapshot
// assumes pins are synchronous to pclk
`timescale 1ns/10ps
module pin_change_detect
(
	input  wire logic   pclk,      // system clock
	input  wire logic   presetn,   // async reset, low
	input  wire logic   ce,        // clock enable
	wake_link_if.detect lnk        // controller link
);
	logic [23:0] prev_q;
	logic [23:0] level_q;
	logic [23:0] snap_q;

	////////////////////////////////////////////////////////////////
	// filter: a level only counts once two samples agree
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prev_q  <= 24'h00_0000;
			level_q <= 24'h00_0000;
		end
		else if (ce)
		begin
			prev_q <= lnk.pins;
			if (lnk.filter_en)
				level_q <= (lnk.pins & prev_q) | (level_q & (lnk.pins | prev_q));
			else
				level_q <= lnk.pins;
		end

	// snapshot of the levels at deep sleep entry
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			snap_q <= 24'h00_0000;
		else if (ce && lnk.arm)
			snap_q <= level_q;

	// masked difference, gated by the global enable
	assign lnk.change = lnk.monitor_en &&
		(|((level_q ^ snap_q) & lnk.mask));
endmodule : pin_change_detect

/* File: verilog/wake_irq_ctrl.sv */
// sticky interrupt status with write-one-to-clear and a mask
// assumes set and clear pulses last one enabled cycle
`timescale 1ns/10ps
module wake_irq_ctrl
(
	input  wire logic  pclk,     // system clock
	input  wire logic  presetn,  // async reset, low
	input  wire logic  ce,       // clock enable
	wake_link_if.irqm  lnk       // controller link
);
	logic [1:0] status_q;
	logic [1:0] mask_q;

	////////////////////////////////////////////////////////////////
	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			status_q <= 2'h0;
		else if (ce)
			status_q <= (status_q & ~lnk.irq_clr) | lnk.irq_set;

	// mask register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mask_q <= 2'h0;
		else if (ce && lnk.mask_wr)
			mask_q <= lnk.mask_wdata;

	assign lnk.irq_status = status_q;
	assign lnk.irq_mask   = mask_q;
endmodule : wake_irq_ctrl

/* File: bench/wake_monitor_checker.sv */
// port assertions for the gpio wake monitor
// assumes external regulator select keeps its reset value of one
`timescale 1ns/10ps
module wake_monitor_checker
(
	input wire logic        pclk,                      // clock
	input wire logic        presetn,                   // reset, low
	input wire logic        psel,                      // apb select
	input wire logic        penable,                   // apb enable
	input wire logic        pwrite,                    // apb direction
	input wire logic [15:0] paddr,                     // apb address
	input wire logic [23:0] gpio_in,                   // pin levels
	input wire logic [31:0] prdata,                    // read data
	input wire logic        pready,                    // apb ready
	input wire logic        pslverr,                   // apb error
	input wire logic        regulator_control_pin_o,   // pin output
	input wire logic        regulator_control_pin_oe,  // pin enable
	input wire logic        vreg_1v8_en,               // 1v8 on
	input wire logic        vreg_1v25_en,              // 1v25 on
	input wire logic        deep_sleep                 // asleep
);
	logic sleep_wr;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// decoded offsets; anything else must answer with an error
	function automatic logic mapped(input logic [15:0] a);
		mapped = a inside {16'h0020, 16'h0024, 16'h0028, 16'h0034,
			16'h0038, 16'h003C, 16'h0040, 16'hBC08, 16'hBC0C, 16'hBC10,
			16'hBC1C, 16'hBC20, 16'hBC24, 16'hBC28, 16'hBC2C, 16'hBC30};
	endfunction : mapped

	// completed write to the sleep register
	assign sleep_wr = psel & penable & pready & pwrite
		& (paddr == wake_pkg::SLEEP_OFF);

	////////////////////////////////////////////////////////////////////////
	a_vreg_off_asleep:
		assert property (deep_sleep |-> !(vreg_1v8_en | vreg_1v25_en))
		else $error("regulator on in deep sleep");
	a_sleep_cause:
		assert property ($rose(deep_sleep) |-> $past(sleep_wr))
		else $error("sleep entered without a sleep write");
	a_pin_low_asleep:
		assert property (deep_sleep |-> regulator_control_pin_oe
			&& !regulator_control_pin_o)
		else $error("regulator pin not pulled low in sleep");
	a_pin_released_awake:
		assert property (!deep_sleep |-> !regulator_control_pin_oe)
		else $error("regulator pin driven while awake");
	a_no_spurious_wake:
		assert property ((deep_sleep && !psel && $stable(gpio_in))[*4]
			|=> deep_sleep)
		else $error("woke without a pin change");
	a_ready_after_setup:
		assert property (psel && !penable |=> pready && psel && penable)
		else $error("no ready one cycle after setup");
	a_error_decode:
		assert property (pready |-> pslverr == !mapped(paddr))
		else $error("error flag does not match address decode");
	a_error_reads_zero:
		assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read returned data");

	c_sleep: cover property ($rose(deep_sleep));
	c_wake: cover property ($fell(deep_sleep));
	c_error: cover property (pready && pslverr);
endmodule : wake_monitor_checker

bind gpio_wake_monitor wake_monitor_checker u_wake_monitor_checker
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .gpio_in(gpio_in), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.regulator_control_pin_o(regulator_control_pin_o),
	.regulator_control_pin_oe(regulator_control_pin_oe),
	.vreg_1v8_en(vreg_1v8_en), .vreg_1v25_en(vreg_1v25_en),
	.deep_sleep(deep_sleep)
);

/* File: bench/ext_pins_model.sv */
// gpio pads and the external regulator enable line
// assumes an external pull-up on the regulator pin
`timescale 1ns/10ps
module ext_pins_model
(
	input  wire logic [23:0] level_req,  // levels asked by the bench
	input  wire logic        pin_o,      // regulator pin output
	input  wire logic        pin_oe,     // regulator pin drive enable
	output logic             pad,        // resolved regulator pin level
	output logic      [23:0] gpio_in     // levels seen by the device
);
	// released pin floats to the pull-up, asking for supply
	assign pad = pin_oe ? pin_o : 1'b1;
	// the regulator pin is also port a pin 7, so it reads back the pad
	assign gpio_in = {level_req[23:8], pad, level_req[6:0]};
endmodule : ext_pins_model

/* File: bench/gpio_wake_monitor_bench.sv */
// self-checking bench for the gpio wake monitor
// assumes the checker is bound and the pin model stands at the far side
`timescale 1ns/10ps
module gpio_wake_monitor_bench;
	typedef struct {logic [15:0] a; logic [31:0] d, e, err;} row_s;
	logic        pclk, presetn, psel, penable, pwrite, pad;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd, er;
	logic        pready, pslverr, pin_o, pin_oe, v18, v125, slp, irq, ack;
	logic [23:0] lvl, gpio;
	logic [5:0]  outs;
	int          bad_count, checked;
	// upper mask bits kept zero by software
	row_s rows [0:4] = '{
		'{wake_pkg::MASK_B_OFF, 32'hA5, 32'hA5, 32'h0},
		'{wake_pkg::MASK_C_OFF, 32'h5A, 32'h5A, 32'h0},
		'{wake_pkg::MASK_A_OFF, 32'h3C, 32'h3C, 32'h0},
		'{16'h0044, 32'hFF, 32'h0, 32'h1},
		'{wake_pkg::FLAGS_OFF, 32'h3FF, 32'h0, 32'h0}};

	// ack rides along at the top; no powerup request is ever made here
	assign outs = {ack, slp, v18, v125, pad, irq};

	gpio_wake_monitor u_gpio_wake_monitor (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_in(gpio), .cpwrupreq(1'b0),
		.csyspwrupreq(1'b0), .pin7_normal_o(1'b0), .pin7_normal_oe(1'b1),
		.regulator_control_pin_o(pin_o), .regulator_control_pin_oe(pin_oe),
		.vreg_1v8_en(v18), .vreg_1v25_en(v125), .deep_sleep(slp),
		.csyspwrupack(ack), .irq(irq));
	ext_pins_model u_ext_pins_model (.level_req(lvl), .pin_o(pin_o),
		.pin_oe(pin_oe), .pad(pad), .gpio_in(gpio));

	////////////////////////////////////////////////////////////////////////
	// clock: 5 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; waits for ready under a bound
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			bad_count++;
			complete_run();
		end
		rd = prdata;
		er = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	// wake is taken within two edges of the change; allow a margin
	task automatic wait_awake;
		int n;
		n = 0;
		while (slp !== 1'b0 && n < 8)
		begin
			@(posedge pclk);
			n++;
		end
		if (slp !== 1'b0)
		begin
			bad_count++;
			complete_run();
		end
		@(posedge pclk);
		@(negedge pclk);
	endtask : wait_awake

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
		{bad_count, checked} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, wake_pkg::MASK_B_OFF, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, wake_pkg::MASK_C_OFF, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, wake_pkg::SRC_EN_OFF, 32'h0);
		check(rd, 32'h200);
		check({26'h0, outs}, 32'h0E);
		$display("reset values done");
		foreach (rows[i])
		begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			check(rd, rows[i].e);
			check(er, rows[i].err);
		end
		$display("register rows done");
		// sleep with port b pin 7 watched, irq masked off
		bus(1'b1, wake_pkg::MASK_B_OFF, 32'h80);
		bus(1'b1, wake_pkg::SRC_EN_OFF, 32'h201);
		bus(1'b1, wake_pkg::SLEEP_OFF, 32'h1);
		@(negedge pclk);
		check({26'h0, outs}, 32'h10);
		@(posedge pclk);
		lvl <= 24'h004000;
		repeat (6) @(negedge pclk);
		check({26'h0, outs}, 32'h10);
		@(posedge pclk);
		lvl <= 24'h00C000;
		wait_awake();
		check({26'h0, outs}, 32'h0E);
		bus(1'b0, wake_pkg::FLAGS_OFF, 32'h0);
		check(rd, 32'h1);
		// irq level trails the mask write by one more edge
		bus(1'b1, wake_pkg::IRQ_MASK_OFF, 32'h1);
		repeat (2) @(negedge pclk);
		check({26'h0, outs}, 32'h0F);
		bus(1'b1, wake_pkg::IRQ_STAT_OFF, 32'h3);
		repeat (2) @(negedge pclk);
		check({26'h0, outs}, 32'h0E);
		// external regulator supplies: software turns internal ones off
		bus(1'b1, wake_pkg::VREG_OFF, 32'h0);
		repeat (2) @(negedge pclk);
		check({26'h0, outs}, 32'h02);
		bus(1'b1, wake_pkg::VREG_OFF, 32'h3);
		$display("pin wake done");
		// monitor off: a change against the snapshot waits for enable
		bus(1'b1, wake_pkg::SRC_EN_OFF, 32'h200);
		bus(1'b1, wake_pkg::SLEEP_OFF, 32'h1);
		lvl <= 24'h004000;
		repeat (6) @(negedge pclk);
		check({26'h0, outs}, 32'h10);
		bus(1'b1, wake_pkg::SRC_EN_OFF, 32'h201);
		wait_awake();
		check({26'h0, outs}, 32'h0F);
		$display("monitor enable done");
		// reset in mid-run brings the masks back to zero
		bus(1'b1, wake_pkg::MASK_C_OFF, 32'hFF);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		bus(1'b0, wake_pkg::MASK_C_OFF, 32'h0);
		check(rd, 32'h0);
		check({26'h0, outs}, 32'h0E);
		$display("second reset done");
		complete_run();
	end
endmodule : gpio_wake_monitor_bench
